// [dv/line_model.sv]
// Remote terminal on channel 0: sends and captures frames
module line_model (
	input  wire logic clk,
	input  wire logic tx_line,
	output logic      rx_line
);
	timeunit 1ns;
	timeprecision 1ps;
	initial rx_line = 1'b1;
	// Drive one level for n cycles
	task automatic hold(input logic v, input int n);
		#1 rx_line = v;
		repeat (n) @(posedge clk);
	endtask
	// Start bit, nb bits LSB first, one stop bit
	task automatic send(input logic [9:0] f, input int nb, input int p);
		hold(1'b0, p);
		for (int i = 0; i < nb; i++)
			hold(f[i], p);
		hold(1'b1, p);
	endtask
	// Short low pulse, well under half a bit
	task automatic spike;
		hold(1'b0, 4);
		hold(1'b1, 1);
	endtask
	// Mid-bit capture of start plus nb bits
	task automatic recv(output logic [11:0] b, input int nb, input int p);
		@(negedge tx_line);
		repeat (p / 2) @(posedge clk);
		for (int i = 0; i <= nb; i++) begin
			b[i] = tx_line;
			repeat (p) @(posedge clk);
		end
	endtask
endmodule // line_model

// [dv/serial_chk.sv]
// Watches channel 0 framing and hand-over, and channel 1 time constant readback
module serial_chk (
	input wire logic            clk,
	input wire logic            rst_n,
	input wire logic [1:0]      tx_write,
	input wire logic [1:0]      tx_empty,
	input wire logic [1:0]      send_break,
	input wire logic [1:0]      serial_out,
	input wire logic [1:0][7:0] tc_wdata,
	input wire logic [1:0]      tc_low_we,
	input wire logic [1:0]      tc_high_we,
	input wire logic [1:0][7:0] tc_low_rd,
	input wire logic [1:0][7:0] tc_high_rd,
	input wire logic [1:0]      rx_valid,
	input wire logic [1:0]      rx_read,
	input wire logic [1:0][7:0] rx_data,
	input wire logic [1:0][2:0] rx_flags
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Break request held long enough to reach the pin
	sequence brk_held;
		send_break[0] [*3];
	endsequence
	reset_idle_a:
	assert property (disable iff (1'b0) !rst_n |=>
		serial_out == 2'h3 && tx_empty == 2'h3) else $error("not idle");
	break_low_a:
	assert property (brk_held |-> !serial_out[0]) else $error("no break");
	buf_fill_a:
	assert property (tx_write[0] |=> !tx_empty[0]) else $error("buf");
	start_bit_a:
	assert property ($rose(tx_empty[0]) && !send_break[0] |=> !serial_out[0])
		else $error("no start bit");
	tc_low_a:
	assert property (tc_low_we[1] |=> tc_low_rd[1] == $past(tc_wdata[1]))
		else $error("tc low");
	tc_high_a:
	assert property (tc_high_we[1] |=> tc_high_rd[1] == $past(tc_wdata[1]))
		else $error("tc high");
	pop_gap_a:
	assert property (rx_read[0] && rx_valid[0] |=> !rx_valid[0])
		else $error("pop gap");
	head_hold_a:
	assert property (rx_valid[0] && !rx_read[0] |=>
		$stable(rx_data[0]) && $stable(rx_flags[0])) else $error("head");
endmodule // serial_chk

bind dual_async_serial_channel serial_chk i_serial_chk (.*);

// [dv/tb.sv]
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_n, serial_in_line_first, serial_in_line_second;
	logic vector_we, master_we, irq_req;
	logic [1:0] tx_write, tx_empty, rx_valid, rx_read, parity_en;
	logic [1:0] parity_odd, send_break, tx_clk_sel, rx_clk_sel;
	logic [1:0] tx_clk_pin, rx_clk_pin, tc_low_we, tc_high_we, brg_out;
	logic [1:0] serial_out, rx_break, ext_clear, modem_watch_en;
	logic [1:0][7:0] tx_data, rx_data, tc_wdata, tc_low_rd, tc_high_rd;
	logic [1:0][2:0] rx_flags;
	logic [1:0][1:0] char_len, stop_sel, tx_div, rx_div, modem_in;
	logic [1:0][1:0] modem_ctl, modem_out, modem_status;
	logic [7:0] vector_wdata, master_wdata;
	logic [7:0] vector_read_first, vector_read_second;
	logic [5:0] irq_pending_read;
	logic [11:0] got;
	int error_cnt = 0;
	int total_checks = 0;
	int cyc = 0;
	dual_async_serial_channel i_dual_async_serial_channel (.*);
	line_model i_line_model (
		.clk     (clk),
		.tx_line (serial_out[0]),
		.rx_line (serial_in_line_first)
	);
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			conclude;
		end
	end
	task automatic step;
		@(posedge clk);
		#1;
	endtask
	task automatic chk(string n, logic [11:0] e, logic [11:0] g);
		total_checks++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", n, e, g);
			error_cnt++;
		end
	endtask
	// One byte into the second time constant
	task automatic tcw(input logic hi, input logic [7:0] v);
		step;
		tc_wdata[1] = v;
		tc_high_we[1] = hi;
		tc_low_we[1] = !hi;
		step;
		tc_high_we[1] = 1'b0;
		tc_low_we[1] = 1'b0;
	endtask
	// Check head entry then pop it
	task automatic pop(input logic [7:0] d, input logic [2:0] f);
		do
			step;
		while (rx_valid[0] !== 1'b1);
		chk("rx_data", d, rx_data[0]);
		chk("rx_flags", f, rx_flags[0]);
		rx_read[0] = 1'b1;
		step;
		rx_read[0] = 1'b0;
		step;
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Main sequence; channel 0 runs off its baud generator, count 0
	initial begin
		{tx_write, rx_read, send_break, tc_low_we, tc_high_we, ext_clear,
			vector_we, master_we, tx_data, tc_wdata, parity_en, parity_odd,
			char_len, stop_sel, tx_div, rx_div, tx_clk_sel, rx_clk_sel,
			tx_clk_pin, rx_clk_pin, modem_in, modem_watch_en, modem_ctl,
			vector_wdata, master_wdata} = '0;
		serial_in_line_second = 1'b1;
		rst_n = 1'b0;
		repeat (4) @(posedge clk);
		#1 rst_n = 1'b1;
		step;
		chk("tc reset", 12'h000, tc_low_rd[1]);
		tcw(1'b0, 8'h3c);
		tcw(1'b1, 8'ha5);
		step;
		chk("tc", 12'ha5, tc_high_rd[1]);
		chk("tc low", 12'h3c, tc_low_rd[1]);
		// Constant zero toggles every cycle; a large one holds
		got[0] = brg_out[0];
		step;
		chk("brg tog", {11'h0, ~got[0]}, brg_out[0]);
		repeat (100) step;
		got[0] = brg_out[1];
		repeat (100) step;
		chk("brg hold", {11'h0, got[0]}, brg_out[1]);
		$display("test done: time constant");
		// 8 bits, even parity, 2 stops, divide by 16
		char_len[0] = 2'h3;
		parity_en[0] = 1'b1;
		stop_sel[0] = serial_pkg::STOP_2;
		tx_div[0] = serial_pkg::DIV_16;
		tx_data[0] = 8'h5b;
		fork
			i_line_model.recv(got, 11, 32);
			begin
				step;
				tx_write[0] = 1'b1;
				step;
				tx_write[0] = 1'b0;
			end
		join
		chk("tx start", 12'h0, got[0]);
		chk("tx data", 12'h5b, got[8:1]);
		chk("tx parity", 12'h1, got[9]);
		chk("tx stop", 12'h3, got[11:10]);
		step;
		send_break[0] = 1'b1;
		repeat (4) step;
		chk("break", 12'h0, serial_out[0]);
		send_break[0] = 1'b0;
		$display("test done: transmit");
		// Shared vector with status code, pending bits, request
		vector_wdata = 8'hf1;
		master_wdata = 8'h09;
		vector_we = 1'b1;
		master_we = 1'b1;
		step;
		vector_we = 1'b0;
		master_we = 1'b0;
		repeat (2) step;
		chk("vec first", 12'hf1, vector_read_first);
		chk("vec second", 12'hf9, vector_read_second);
		chk("pending", 12'h10, irq_pending_read);
		chk("irq", 12'h1, irq_req);
		$display("test done: interrupt registers");
		// 7 bits, no parity, divide by 32
		char_len[0] = 2'h2;
		parity_en[0] = 1'b0;
		rx_div[0] = serial_pkg::DIV_32;
		i_line_model.spike();
		repeat (200) step;
		chk("spike", 12'h0, rx_valid[0]);
		for (int i = 0; i < 4; i++)
			i_line_model.send(10'h41 + 10'(i), 7, 64);
		pop(8'h41, 3'h0);
		pop(8'h42, 3'h0);
		pop(8'h44, 3'h4);
		repeat (4) step;
		chk("fifo empty", 12'h0, rx_valid[0]);
		$display("test done: receive");
		// Break on the line, its pending bit, then its end
		i_line_model.hold(1'b0, 700);
		step;
		chk("break", 12'h1, rx_break[0]);
		chk("ext", 12'h1, irq_pending_read[3]);
		ext_clear[0] = 1'b1;
		step;
		ext_clear[0] = 1'b0;
		step;
		chk("ext clear", 12'h0, irq_pending_read[3]);
		i_line_model.hold(1'b1, 10);
		step;
		chk("break end", 12'h0, rx_break[0]);
		chk("ext end", 12'h1, irq_pending_read[3]);
		pop(8'h00, 3'h2);
		$display("test done: break");
		conclude;
	end
endmodule // tb

// [src/dual_async_serial_channel.sv]
// Behaviour
// - Character data length five to eight bits
// - Optional parity, even or odd selectable
// - Stop period one, one and a half, or two bits
// - Break forces serial output low anytime
// - Break start and end both raise request
// - Recheck low input half bit later
// - High on recheck means spike, ignored
// - Framing and overrun stored with character
// - After framing error, wait half bit
// - Divide supplied clock by 1/16/32/64
// - Transmit and receive clocks chosen independently
// - Three-deep receive FIFO plus shifter
// - Byte holding buffer feeds eleven-bit shifter
// - Receive path depends on character length
// - Two identical independent full-duplex channels
// - Vector and master control shared, single
// - Second channel reads vector with status
// - Pending bits readable through first channel
// - Sixteen-bit time constant, two readable bytes
// - Per-channel control, sync and status registers
// - Modem pins monitored or general purpose
// - Baud counter reloads, toggles at zero
module dual_async_serial_channel (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [1:0][7:0]  tx_data,
	input  wire logic [1:0]       tx_write,
	output logic      [1:0]       tx_empty,
	output logic      [1:0][7:0]  rx_data,
	output logic      [1:0][2:0]  rx_flags,
	output logic      [1:0]       rx_valid,
	input  wire logic [1:0]       rx_read,
	input  wire logic [1:0][1:0]  char_len,
	input  wire logic [1:0]       parity_en,
	input  wire logic [1:0]       parity_odd,
	input  wire logic [1:0][1:0]  stop_sel,
	input  wire logic [1:0]       send_break,
	input  wire logic [1:0][1:0]  tx_div,
	input  wire logic [1:0][1:0]  rx_div,
	input  wire logic [1:0]       tx_clk_sel,
	input  wire logic [1:0]       rx_clk_sel,
	input  wire logic [1:0]       tx_clk_pin,
	input  wire logic [1:0]       rx_clk_pin,
	input  wire logic [1:0][7:0]  tc_wdata,
	input  wire logic [1:0]       tc_low_we,
	input  wire logic [1:0]       tc_high_we,
	output logic      [1:0][7:0]  tc_low_rd,
	output logic      [1:0][7:0]  tc_high_rd,
	output logic      [1:0]       brg_out,
	input  wire logic             serial_in_line_first,
	input  wire logic             serial_in_line_second,
	output logic      [1:0]       serial_out,
	output logic      [1:0]       rx_break,
	input  wire logic [1:0]       ext_clear,
	input  wire logic [1:0][1:0]  modem_in,
	input  wire logic [1:0]       modem_watch_en,
	input  wire logic [1:0][1:0]  modem_ctl,
	output logic      [1:0][1:0]  modem_out,
	output logic      [1:0][1:0]  modem_status,
	input  wire logic [7:0]       vector_wdata,
	input  wire logic             vector_we,
	input  wire logic [7:0]       master_wdata,
	input  wire logic             master_we,
	output logic      [7:0]       vector_read_first,
	output logic      [7:0]       vector_read_second,
	output logic      [5:0]       irq_pending_read,
	output logic                  irq_req
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Clock cycles of the supplied clock per bit
	function automatic logic [6:0] div_ticks(input logic [1:0] code);
		case (code)
			serial_pkg::DIV_16: div_ticks = serial_pkg::TICKS_X16;
			serial_pkg::DIV_32: div_ticks = serial_pkg::TICKS_X32;
			serial_pkg::DIV_64: div_ticks = serial_pkg::TICKS_X64;
			default:            div_ticks = serial_pkg::TICKS_X1;
		endcase
	endfunction

	// Mask of the valid data bits for a length code
	function automatic logic [7:0] char_mask(input logic [1:0] code);
		char_mask = 8'hff >> (2'h3 - code);
	endfunction

	// Pointer step over three slots
	function automatic logic [1:0] ptr_inc(input logic [1:0] p);
		ptr_inc = (p == 2'h2) ? 2'h0 : p + 2'h1;
	endfunction

	// Start bit, data, optional parity, ones above
	function automatic logic [10:0] build_frame(input logic [7:0] d,
		input logic [3:0] n, input logic pe, input logic po);
		logic [9:0] d10;
		logic       p;
		d10 = {2'b00, d};
		p = (^d) ^ po;
		build_frame = serial_pkg::SHIFT_IDLE;
		build_frame[0] = 1'b0;
		for (int i = 0; i < 10; i++) begin
			if (4'(i) < n) begin
				build_frame[i + 1] = d10[i];
			end else if (4'(i) == n && pe) begin
				build_frame[i + 1] = p;
			end
		end
	endfunction

	logic [1:0]      rx_pin;
	logic [1:0][2:0] pend;

	assign rx_pin = {serial_in_line_second, serial_in_line_first};

	// ------------------------------------------------------------
	// Channels
	// ------------------------------------------------------------
	for (genvar ch = 0; ch < serial_pkg::NUM_CH; ch++) begin : g_ch
		logic [2:0]  rx_sync_reg, txc_sync_reg, rxc_sync_reg;
		logic [1:0]  mdm_s1_reg, mdm_s2_reg, mdm_stat_reg, mdm_out_reg;
		logic [15:0] tc_reg, brg_cnt_reg;
		logic        brg_reg;
		logic [7:0]  tx_buf_reg;
		logic        tx_full_reg, tx_pend_reg, ser_out_reg, ext_reg;
		logic [10:0] tx_sr_reg;
		logic [3:0]  tx_bits_reg, rx_bits_reg;
		logic [7:0]  tx_tcnt_reg, rx_tcnt_reg;
		logic [8:0]  rx_sr_reg;
		logic [1:0]  head_reg, tail_reg, count_reg;
		logic        fresh_reg;
		logic [serial_pkg::ENTRY_W-1:0] rd_entry;
		serial_pkg::tx_state_t tx_state_reg;
		serial_pkg::rx_state_t rx_state_reg;

		// Synchronisers; stage 2 feeds edge history in stage 3
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				rx_sync_reg  <= 3'h7;
				txc_sync_reg <= 3'h0;
				rxc_sync_reg <= 3'h0;
				mdm_s1_reg   <= 2'h0;
				mdm_s2_reg   <= 2'h0;
			end else begin
				rx_sync_reg  <= {rx_sync_reg[1:0], rx_pin[ch]};
				txc_sync_reg <= {txc_sync_reg[1:0], tx_clk_pin[ch]};
				rxc_sync_reg <= {rxc_sync_reg[1:0], rx_clk_pin[ch]};
				mdm_s1_reg   <= modem_in[ch];
				mdm_s2_reg   <= mdm_s1_reg;
			end
		end

		// Baud generator: reload at zero, toggle output
		logic brg_zero, brg_rise, tx_tick, rx_tick, rx_line;
		assign brg_zero = (brg_cnt_reg == 16'h0000);
		assign brg_rise = brg_zero & ~brg_reg;
		assign tx_tick  = tx_clk_sel[ch] ? (txc_sync_reg[1] &
			~txc_sync_reg[2]) : brg_rise;
		assign rx_tick  = rx_clk_sel[ch] ? (rxc_sync_reg[1] &
			~rxc_sync_reg[2]) : brg_rise;
		assign rx_line  = rx_sync_reg[1];

		always_ff @(posedge clk) begin
			if (!rst_n) begin
				tc_reg      <= serial_pkg::TC_RESET;
				brg_cnt_reg <= serial_pkg::TC_RESET;
				brg_reg     <= 1'b1;
			end else begin
				if (tc_low_we[ch])
					tc_reg[7:0] <= tc_wdata[ch];
				if (tc_high_we[ch])
					tc_reg[15:8] <= tc_wdata[ch];
				if (brg_zero) begin
					brg_reg     <= ~brg_reg;
					brg_cnt_reg <= tc_reg;
				end else begin
					brg_cnt_reg <= brg_cnt_reg - 16'h0001;
				end
			end
		end

		// Character format and bit timing per direction
		logic [3:0] len_bits, tx_nbits, rx_nbits;
		logic [6:0] tx_ticks, rx_ticks;
		logic [2:0] halves;
		logic [8:0] stop_prod;
		logic [7:0] tx_bit_last, tx_stop_last, rx_bit_last, rx_half_last;
		assign len_bits = serial_pkg::MIN_CHAR_BITS + {2'b00, char_len[ch]};
		assign rx_nbits = len_bits + {3'b000, parity_en[ch]};
		assign tx_nbits = rx_nbits + 4'h1;
		assign tx_ticks = div_ticks(tx_div[ch]);
		assign rx_ticks = div_ticks(rx_div[ch]);
		assign halves = (stop_sel[ch] == serial_pkg::STOP_1) ?
			serial_pkg::HALVES_1 : (stop_sel[ch] == serial_pkg::STOP_1_5) ?
			serial_pkg::HALVES_1_5 : serial_pkg::HALVES_2;
		assign stop_prod = {2'b00, tx_ticks} * {6'h00, halves};
		assign tx_stop_last = stop_prod[8:1] - 8'h01;
		assign tx_bit_last  = {1'b0, tx_ticks} - 8'h01;
		assign rx_bit_last  = {1'b0, rx_ticks} - 8'h01;
		assign rx_half_last = (rx_ticks == serial_pkg::TICKS_X1) ? 8'h00 :
			{2'b00, rx_ticks[6:1]} - 8'h01;

		// Transmitter: holding buffer into shift register
		logic tx_load, tx_fire;
		assign tx_fire = tx_tick & (tx_tcnt_reg == 8'h00);
		assign tx_load = tx_tick & tx_full_reg &
			((tx_state_reg == serial_pkg::TX_IDLE) |
			(tx_state_reg == serial_pkg::TX_STOP & tx_fire));

		always_ff @(posedge clk) begin
			if (!rst_n) begin
				tx_state_reg <= serial_pkg::TX_IDLE;
				tx_sr_reg    <= serial_pkg::SHIFT_IDLE;
				tx_bits_reg  <= 4'h0;
				tx_tcnt_reg  <= 8'h00;
			end else if (tx_load) begin
				tx_sr_reg    <= build_frame(tx_buf_reg, len_bits,
					parity_en[ch], parity_odd[ch]);
				tx_bits_reg  <= tx_nbits;
				tx_tcnt_reg  <= tx_bit_last;
				tx_state_reg <= serial_pkg::TX_BITS;
			end else if (tx_tick && !tx_fire) begin
				tx_tcnt_reg <= tx_tcnt_reg - 8'h01;
			end else if (tx_fire) begin
				case (tx_state_reg)
					serial_pkg::TX_BITS: begin
						tx_sr_reg   <= {1'b1, tx_sr_reg[10:1]};
						tx_bits_reg <= tx_bits_reg - 4'h1;
						if (tx_bits_reg == 4'h1) begin
							tx_state_reg <= serial_pkg::TX_STOP;
							tx_tcnt_reg  <= tx_stop_last;
						end else begin
							tx_tcnt_reg <= tx_bit_last;
						end
					end
					serial_pkg::TX_STOP: tx_state_reg <= serial_pkg::TX_IDLE;
					default: tx_state_reg <= serial_pkg::TX_IDLE;
				endcase
			end
		end

		// Buffer flag, pending flag (set wins) and line driver
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				tx_buf_reg  <= 8'h00;
				tx_full_reg <= 1'b0;
				tx_pend_reg <= 1'b0;
				ser_out_reg <= 1'b1;
			end else begin
				if (tx_write[ch])
					tx_buf_reg <= tx_data[ch];
				tx_full_reg <= tx_write[ch] | (tx_full_reg & ~tx_load);
				tx_pend_reg <= tx_load | (tx_pend_reg & ~tx_write[ch]);
				ser_out_reg <= ~send_break[ch] &
					((tx_state_reg != serial_pkg::TX_BITS) | tx_sr_reg[0]);
			end
		end

		// Receiver: align by length, check parity
		logic [8:0] rx_word;
		logic [7:0] rx_char;
		logic       rx_fire, rx_push, rx_perr, rx_ferr, brk_start, brk_end;
		assign rx_word = rx_sr_reg >> (4'h9 - rx_nbits);
		assign rx_char = rx_word[7:0] & char_mask(char_len[ch]);
		assign rx_perr = parity_en[ch] &
			(rx_word[len_bits] != ((^rx_char) ^ parity_odd[ch]));
		assign rx_fire = rx_tick & (rx_tcnt_reg == 8'h00);
		assign rx_push = rx_fire & (rx_state_reg == serial_pkg::RX_STOP);
		assign rx_ferr = ~rx_line;
		assign brk_start = rx_push & rx_ferr & (rx_sr_reg == 9'h000);
		assign brk_end = rx_tick & rx_line &
			(rx_state_reg == serial_pkg::RX_BREAK);

		always_ff @(posedge clk) begin
			if (!rst_n) begin
				rx_state_reg <= serial_pkg::RX_IDLE;
				rx_sr_reg    <= 9'h000;
				rx_bits_reg  <= 4'h0;
				rx_tcnt_reg  <= 8'h00;
			end else if (rx_tick && !rx_fire) begin
				rx_tcnt_reg <= rx_tcnt_reg - 8'h01;
			end else if (rx_tick) begin
				case (rx_state_reg)
					serial_pkg::RX_IDLE: if (!rx_line) begin
						rx_state_reg <= serial_pkg::RX_CONFIRM;
						rx_tcnt_reg  <= rx_half_last;
					end
					serial_pkg::RX_CONFIRM: if (!rx_line) begin
						rx_state_reg <= serial_pkg::RX_DATA;
						rx_bits_reg  <= rx_nbits;
						rx_sr_reg    <= 9'h000;
						rx_tcnt_reg  <= rx_bit_last;
					end else begin
						rx_state_reg <= serial_pkg::RX_IDLE;
					end
					serial_pkg::RX_DATA: begin
						rx_sr_reg   <= {rx_line, rx_sr_reg[8:1]};
						rx_bits_reg <= rx_bits_reg - 4'h1;
						rx_tcnt_reg <= rx_bit_last;
						if (rx_bits_reg == 4'h1)
							rx_state_reg <= serial_pkg::RX_STOP;
					end
					serial_pkg::RX_STOP: if (brk_start) begin
						rx_state_reg <= serial_pkg::RX_BREAK;
					end else if (rx_ferr) begin
						rx_state_reg <= serial_pkg::RX_HOLD;
						rx_tcnt_reg  <= rx_half_last;
					end else begin
						rx_state_reg <= serial_pkg::RX_IDLE;
					end
					serial_pkg::RX_BREAK: if (rx_line)
						rx_state_reg <= serial_pkg::RX_IDLE;
					serial_pkg::RX_HOLD: rx_state_reg <= serial_pkg::RX_IDLE;
					default: rx_state_reg <= serial_pkg::RX_IDLE;
				endcase
			end
		end

		// Receive FIFO; when full the newest slot is overwritten
		logic       fifo_full, rx_pop, ovr;
		logic [1:0] wr_addr;
		logic [serial_pkg::ENTRY_W-1:0] wr_entry;
		assign fifo_full = (count_reg == 2'(serial_pkg::FIFO_DEPTH));
		assign rx_pop  = rx_read[ch] & rx_valid[ch];
		assign ovr     = fifo_full & ~rx_pop;
		assign wr_addr = ovr ? ((tail_reg == 2'h0) ? 2'h2 :
			tail_reg - 2'h1) : tail_reg;
		assign wr_entry = {ovr, rx_ferr, rx_perr, rx_char};

		always_ff @(posedge clk) begin
			if (!rst_n) begin
				head_reg  <= 2'h0;
				tail_reg  <= 2'h0;
				count_reg <= 2'h0;
				fresh_reg <= 1'b0;
			end else begin
				fresh_reg <= ~(rx_push | rx_pop);
				if (rx_pop)
					head_reg <= ptr_inc(head_reg);
				if (rx_push && !ovr)
					tail_reg <= ptr_inc(tail_reg);
				if (rx_push && !ovr && !rx_pop)
					count_reg <= count_reg + 2'h1;
				else if (rx_pop && !rx_push)
					count_reg <= count_reg - 2'h1;
			end
		end

		entry_mem u_mem (
			.clk     (clk),
			.rst_n   (rst_n),
			.wr_en   (rx_push),
			.wr_addr (wr_addr),
			.wr_data (wr_entry),
			.rd_addr (head_reg),
			.rd_data (rd_entry)
		);

		// Modem lines and status events, set wins over clear
		logic mdm_chg;
		assign mdm_chg = modem_watch_en[ch] & (mdm_s2_reg != mdm_stat_reg);

		always_ff @(posedge clk) begin
			if (!rst_n) begin
				mdm_stat_reg <= 2'h0;
				mdm_out_reg  <= 2'h0;
				ext_reg      <= 1'b0;
			end else begin
				mdm_stat_reg <= mdm_s2_reg;
				mdm_out_reg  <= modem_ctl[ch];
				ext_reg <= brk_start | brk_end | mdm_chg |
					(ext_reg & ~ext_clear[ch]);
			end
		end

		// Per-channel outputs and pending bits
		assign tx_empty[ch]     = ~tx_full_reg;
		assign rx_valid[ch]     = (count_reg != 2'h0) & fresh_reg;
		assign rx_data[ch]      = rd_entry[7:0];
		assign rx_flags[ch]     = rd_entry[serial_pkg::ERR_OVERRUN:
			serial_pkg::ERR_PARITY];
		assign tc_low_rd[ch]    = tc_reg[7:0];
		assign tc_high_rd[ch]   = tc_reg[15:8];
		assign brg_out[ch]      = brg_reg;
		assign serial_out[ch]   = ser_out_reg;
		assign rx_break[ch]     = (rx_state_reg == serial_pkg::RX_BREAK);
		assign modem_out[ch]    = mdm_out_reg;
		assign modem_status[ch] = mdm_stat_reg;
		assign pend[ch][serial_pkg::PEND_RX]  = (count_reg != 2'h0);
		assign pend[ch][serial_pkg::PEND_TX]  = tx_pend_reg;
		assign pend[ch][serial_pkg::PEND_EXT] = ext_reg;
	end

	// ------------------------------------------------------------
	// Shared interrupt registers
	// ------------------------------------------------------------
	logic [7:0] shared_vector_write_reg, master_irq_control_reg;
	logic [7:0] vector_read_reg, irq_src_vec;
	logic [5:0] irq_pending_read_reg;
	logic       irq_req_reg;
	logic [2:0] vcode;

	// Highest pending source picks the status code
	assign vcode = pend[0][serial_pkg::PEND_RX]  ? serial_pkg::VCODE_A_RX :
		pend[0][serial_pkg::PEND_TX]  ? serial_pkg::VCODE_A_TX :
		pend[0][serial_pkg::PEND_EXT] ? serial_pkg::VCODE_A_EX :
		pend[1][serial_pkg::PEND_RX]  ? serial_pkg::VCODE_B_RX :
		pend[1][serial_pkg::PEND_TX]  ? serial_pkg::VCODE_B_TX :
		pend[1][serial_pkg::PEND_EXT] ? serial_pkg::VCODE_B_EX :
		serial_pkg::VCODE_NONE;
	assign irq_src_vec = shared_vector_write_reg;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			shared_vector_write_reg <= serial_pkg::VECTOR_RESET;
			master_irq_control_reg  <= serial_pkg::MASTER_RESET;
			vector_read_reg         <= serial_pkg::VECTOR_RESET;
			irq_pending_read_reg    <= 6'h00;
			irq_req_reg             <= 1'b0;
		end else begin
			if (vector_we)
				shared_vector_write_reg <= vector_wdata;
			if (master_we)
				master_irq_control_reg <= master_wdata;
			vector_read_reg <= irq_src_vec;
			if (master_irq_control_reg[serial_pkg::MASTER_VIS])
				vector_read_reg[serial_pkg::VEC_LSB +: 3] <= vcode;
			irq_pending_read_reg <= {pend[0], pend[1]};
			irq_req_reg <= master_irq_control_reg[serial_pkg::MASTER_MIE] &
				(|{pend[0], pend[1]});
		end
	end

	assign vector_read_first  = shared_vector_write_reg;
	assign vector_read_second = vector_read_reg;
	assign irq_pending_read   = irq_pending_read_reg;
	assign irq_req            = irq_req_reg;

endmodule // dual_async_serial_channel

// [src/entry_mem.sv]
// Three-entry receive store, registered read port
module entry_mem (
	input  wire logic                               clk,
	input  wire logic                               rst_n,
	input  wire logic                               wr_en,
	input  wire logic [1:0]                         wr_addr,
	input  wire logic [serial_pkg::ENTRY_W-1:0]     wr_data,
	input  wire logic [1:0]                         rd_addr,
	output logic      [serial_pkg::ENTRY_W-1:0]     rd_data
);

	logic [serial_pkg::ENTRY_W-1:0] mem_reg [serial_pkg::FIFO_DEPTH];
	logic [serial_pkg::ENTRY_W-1:0] rd_data_reg;

	// Write port and registered read
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < serial_pkg::FIFO_DEPTH; i++) begin
				mem_reg[i] <= '0;
			end
			rd_data_reg <= '0;
		end else begin
			if (wr_en) begin
				mem_reg[wr_addr] <= wr_data;
			end
			rd_data_reg <= mem_reg[rd_addr];
		end
	end

	assign rd_data = rd_data_reg;

endmodule // entry_mem

// [src/serial_pkg.sv]
package serial_pkg;

	// ------------------------------------------------------------
	// Widths and depths
	// ------------------------------------------------------------
	localparam int NUM_CH     = 2;
	localparam int DATA_W     = 8;
	localparam int SHIFT_W    = 11;
	localparam int FIFO_DEPTH = 3;
	localparam int ENTRY_W    = 11;

	// Receive entry layout: data in [7:0], then error flags
	localparam int ERR_PARITY  = 8;
	localparam int ERR_FRAME   = 9;
	localparam int ERR_OVERRUN = 10;

	// ------------------------------------------------------------
	// Clock division, stop length and timing counts
	// ------------------------------------------------------------
	localparam logic [1:0] DIV_1  = 2'h0;
	localparam logic [1:0] DIV_16 = 2'h1;
	localparam logic [1:0] DIV_32 = 2'h2;
	localparam logic [1:0] DIV_64 = 2'h3;
	localparam logic [6:0] TICKS_X1  = 7'h01;
	localparam logic [6:0] TICKS_X16 = 7'h10;
	localparam logic [6:0] TICKS_X32 = 7'h20;
	localparam logic [6:0] TICKS_X64 = 7'h40;
	localparam logic [1:0] STOP_1   = 2'h0;
	localparam logic [1:0] STOP_1_5 = 2'h1;
	localparam logic [1:0] STOP_2   = 2'h2;
	localparam logic [2:0] HALVES_1   = 3'h2;
	localparam logic [2:0] HALVES_1_5 = 3'h3;
	localparam logic [2:0] HALVES_2   = 3'h4;
	localparam logic [3:0] MIN_CHAR_BITS = 4'h5;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [15:0] TC_RESET     = 16'h0000;
	localparam logic [7:0]  VECTOR_RESET = 8'h00;
	localparam logic [7:0]  MASTER_RESET = 8'h00;
	localparam logic [10:0] SHIFT_IDLE   = 11'h7ff;

	// ------------------------------------------------------------
	// Interrupt control, pending bits and vector status codes
	// ------------------------------------------------------------
	localparam int MASTER_VIS = 0;
	localparam int MASTER_MIE = 3;
	localparam int PEND_EXT   = 0;
	localparam int PEND_TX    = 1;
	localparam int PEND_RX    = 2;
	localparam int VEC_LSB    = 1;
	localparam logic [2:0] VCODE_A_RX = 3'h6;
	localparam logic [2:0] VCODE_A_TX = 3'h4;
	localparam logic [2:0] VCODE_A_EX = 3'h5;
	localparam logic [2:0] VCODE_B_RX = 3'h2;
	localparam logic [2:0] VCODE_B_TX = 3'h0;
	localparam logic [2:0] VCODE_B_EX = 3'h1;
	localparam logic [2:0] VCODE_NONE = 3'h3;

	typedef enum logic [2:0] {
		RX_IDLE, RX_CONFIRM, RX_DATA, RX_STOP, RX_BREAK, RX_HOLD
	} rx_state_t;

	typedef enum logic [1:0] {TX_IDLE, TX_BITS, TX_STOP} tx_state_t;

endpackage
